// [inc/tsr_map.svh]
// tsr_map.svh: register offsets, field positions, reset values, timing counts
// assumes: included by bare name from design, checker and bench modules
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define TSR_ADDR_REVISION 7'h10
`define TSR_ADDR_TEMP_CTL 7'h4E
`define TSR_ADDR_TEMP_VAL 7'h4F
`define TSR_ADDR_LNA 7'h58
`define TSR_ADDR_FADING 7'h6F
`define TSR_ADDR_LOWIDX 7'h71
// ****************************************
// fields and reset values
// ****************************************
`define TSR_TRIG_BIT 3
`define TSR_BUSY_BIT 2
`define TSR_TEMP_CTL_FIXED 8'h01
`define TSR_LNA_RESET 8'h1B
`define TSR_LNA_HIGH 8'h2D
`define TSR_FADING_RESET 8'h30
`define TSR_FADING_NORMAL 8'h00
`define TSR_FADING_LOWIDX 8'h10
`define TSR_LOWIDX_RESET 8'h00
`define TSR_OFFSET_STEP_HZ 488
// ****************************************
// host-side timing (units as printed)
// ****************************************
`define TSR_CLK_MHZ 100
`define TSR_POR_WAIT_MS 10
`define TSR_MRST_PULSE_US 100
`define TSR_MRST_WAIT_MS 5
`define TSR_POR_WAIT_CYC (`TSR_POR_WAIT_MS * 1000 * `TSR_CLK_MHZ)
`define TSR_MRST_PULSE_CYC (`TSR_MRST_PULSE_US * `TSR_CLK_MHZ)
`define TSR_MRST_WAIT_CYC (`TSR_MRST_WAIT_MS * 1000 * `TSR_CLK_MHZ)
`endif

// [inc/tsr_pkg.sv]
// tsr_pkg.sv: types shared by both ends
// assumes: nothing beyond the map header
package tsr_pkg;
	typedef logic [6:0] tsr_addr_t;
	typedef logic [7:0] tsr_byte_t;
	typedef enum logic [3:0] {
		TSR_H_POR = 4'b0001,
		TSR_H_PULSE = 4'b0010,
		TSR_H_WAIT = 4'b0100,
		TSR_H_READY = 4'b1000
	} tsr_host_state_t;
	typedef enum logic [1:0] {
		TSR_M_IDLE = 2'b01,
		TSR_M_RUN = 2'b10
	} tsr_meas_state_t;
endpackage

// [inc/tsr_link_if.sv]
// tsr_link_if.sv: register access link plus reset and clock-out pins
// assumes: one shared clock; device and checker resolve the reset pin level
`timescale 1ns/100ps
interface tsr_link_if;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic rst_pin_out;
	logic rst_pin_oe;
	logic clock_output_pin;
	modport dev (input addr, input wdata, input wr, input rd,
		output rdata, input rst_pin_out, input rst_pin_oe,
		output clock_output_pin);
	modport host (output addr, output wdata, output wr, output rd,
		input rdata, output rst_pin_out, output rst_pin_oe,
		input clock_output_pin);
endinterface // tsr_link_if

// [hw/tsr_meas.sv]
// tsr_meas.sv: temperature conversion sequencer
// assumes: start is a one-cycle pulse on clk_sys
`timescale 1ns/100ps
`include "tsr_map.svh"
module tsr_meas #(
	parameter int CONV_CYCLES = 64
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic start,
	input wire logic [7:0] sensor_code,
	output logic temp_conv_in_progress,
	output logic [7:0] temp_reading
);
	import tsr_pkg::*;
	tsr_meas_state_t state, next_state;
	logic [15:0] cnt, next_cnt;
	logic [7:0] next_temp_reading;
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_temp_reading = temp_reading;
		unique case (state)
			TSR_M_IDLE: begin
				if (start) begin
					next_state = TSR_M_RUN;
					next_cnt = 16'(CONV_CYCLES - 1);
				end
			end
			TSR_M_RUN: begin
				if (cnt == 16'h0000) begin
					next_state = TSR_M_IDLE;
					next_temp_reading = ~sensor_code;
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			default: next_state = TSR_M_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= TSR_M_IDLE;
			cnt <= 16'h0000;
			temp_reading <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			temp_reading <= next_temp_reading;
		end
	end
	assign temp_conv_in_progress = (state == TSR_M_RUN);
endmodule // tsr_meas

// [hw/tsr_dev.sv]
// tsr_dev.sv: device end, temperature and tuning registers
// assumes: host keeps strobes one cycle; reset pin arrives as out and enable, resolved here
// Functional notes
// - trigger bit starts conversion, reads zero
// - busy bit high throughout conversion
// - receive blocked while converting
// - reading counts up as temperature falls
// - lna select: 0x1B normal, 0x2D high
// - fading margin 0x00/0x10/0x30, reset 0x30
// - offset times 488 Hz when enabled
// - host waits 10 ms after power-on
// - host floats reset pin during power-on
// - clock-out activity signals ready
// - manual reset: pin high about 100 us
// - host waits 5 ms after manual reset
// - revision code readable at 0x10
`timescale 1ns/100ps
`include "tsr_map.svh"
module tsr_dev #(
	parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
	parameter int CONV_CYCLES = 64
) (
	input wire logic clk_sys,
	input wire logic resetn,
	tsr_link_if.dev link,
	input wire logic [7:0] sensor_code,
	output logic rx_allowed,
	output logic lna_high_sens,
	output logic [7:0] fading_margin,
	input wire logic low_index_corr_enable,
	output logic signed [17:0] freq_offset_hz
);
	import tsr_pkg::*;
	// ****************************************
	// reset pin sync and chip reset
	// ****************************************
	logic rp_s1, rp_s2, chip_rst;
	logic [7:0] lna_gain_choice, next_lna;
	logic [7:0] fading_margin_choice, next_fading;
	logic [7:0] low_index_corr_shift, next_shift;
	logic [7:0] rdata, next_rdata;
	logic clk_div, next_clk_div;
	logic busy, start;
	logic [7:0] temp_reading;
	logic next_rx, next_lhs;
	logic [17:0] next_off;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rp_s1 <= 1'b0;
			rp_s2 <= 1'b0;
		end else begin
			rp_s1 <= link.rst_pin_oe & link.rst_pin_out;
			rp_s2 <= rp_s1;
		end
	end
	// pin high holds the chip in reset
	assign chip_rst = !resetn || rp_s2;
	// ****************************************
	// register writes and reads
	// ****************************************
	// write of trigger bit fires a start pulse
	assign start = link.wr && link.addr == `TSR_ADDR_TEMP_CTL
		&& link.wdata[`TSR_TRIG_BIT];
	always_comb begin
		next_lna = lna_gain_choice;
		next_fading = fading_margin_choice;
		next_shift = low_index_corr_shift;
		next_rdata = 8'h00;
		if (link.wr) begin
			unique case (link.addr)
				`TSR_ADDR_LNA: next_lna = link.wdata;
				`TSR_ADDR_FADING: next_fading = link.wdata;
				`TSR_ADDR_LOWIDX: next_shift = link.wdata;
				default: ;
			endcase
		end
		if (link.rd) begin
			unique case (link.addr)
				`TSR_ADDR_REVISION: next_rdata = REVISION;
				`TSR_ADDR_TEMP_CTL: next_rdata = `TSR_TEMP_CTL_FIXED
					| {5'b00000, busy, 2'b00};
				`TSR_ADDR_TEMP_VAL: next_rdata = temp_reading;
				`TSR_ADDR_LNA: next_rdata = lna_gain_choice;
				`TSR_ADDR_FADING: next_rdata = fading_margin_choice;
				`TSR_ADDR_LOWIDX: next_rdata = low_index_corr_shift;
				default: next_rdata = 8'h00;
			endcase
		end
		next_rx = !busy && !start;
		next_lhs = (lna_gain_choice == `TSR_LNA_HIGH);
		next_off = low_index_corr_enable
			? 18'($signed(low_index_corr_shift) * `TSR_OFFSET_STEP_HZ)
			: 18'h0_0000;
		// clock-out toggles only out of reset
		next_clk_div = !clk_div;
	end
	always_ff @(posedge clk_sys) begin
		if (chip_rst) begin
			lna_gain_choice <= `TSR_LNA_RESET;
			fading_margin_choice <= `TSR_FADING_RESET;
			low_index_corr_shift <= `TSR_LOWIDX_RESET;
			rdata <= 8'h00;
			clk_div <= 1'b0;
			rx_allowed <= 1'b0;
			lna_high_sens <= 1'b0;
			fading_margin <= `TSR_FADING_RESET;
			freq_offset_hz <= 18'h0_0000;
		end else begin
			lna_gain_choice <= next_lna;
			fading_margin_choice <= next_fading;
			low_index_corr_shift <= next_shift;
			rdata <= next_rdata;
			clk_div <= next_clk_div;
			rx_allowed <= next_rx;
			lna_high_sens <= next_lhs;
			fading_margin <= fading_margin_choice;
			freq_offset_hz <= next_off;
		end
	end
	assign link.rdata = rdata;
	assign link.clock_output_pin = clk_div;
	// ****************************************
	// conversion engine
	// ****************************************
	// one engine, start ignored while busy
	tsr_meas #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_meas (
		.clk_sys(clk_sys),
		.resetn(!chip_rst),
		.start(start),
		.sensor_code(sensor_code),
		.temp_conv_in_progress(busy),
		.temp_reading(temp_reading)
	);
endmodule // tsr_dev

// [hw/tsr_host.sv]
// tsr_host.sv: host end, reset sequencing and register command port
// assumes: device on the same clk_sys; software port one-cycle strobes
`timescale 1ns/100ps
`include "tsr_map.svh"
module tsr_host #(
	parameter int POR_WAIT_CYC = `TSR_POR_WAIT_CYC,
	parameter int MRST_PULSE_CYC = `TSR_MRST_PULSE_CYC,
	parameter int MRST_WAIT_CYC = `TSR_MRST_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	tsr_link_if.host link,
	input wire logic sw_reset_req,
	input wire logic [6:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata,
	output logic ready
);
	import tsr_pkg::*;
	tsr_host_state_t state, next_state;
	logic [31:0] cnt, next_cnt;
	logic ck_s1, ck_s2, ck_s3;
	logic [6:0] addr, next_addr;
	logic [7:0] wdata, next_wdata;
	logic wr, next_wr, rd, next_rd, rd_d;
	logic pin_out, next_pin_out, pin_oe, next_pin_oe, next_ready;
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_pin_out = 1'b0;
		next_pin_oe = 1'b0;
		next_ready = 1'b0;
		unique case (state)
			// wait 10 ms, or clock activity
			TSR_H_POR: begin
				if (cnt == 32'h0000_0000 || ck_s2 != ck_s3) begin
					next_state = TSR_H_READY;
					next_ready = 1'b1;
				end else begin
					next_cnt = cnt - 32'h0000_0001;
				end
			end
			// drive reset pin high about 100 us
			TSR_H_PULSE: begin
				next_pin_out = 1'b1;
				next_pin_oe = 1'b1;
				if (cnt == 32'h0000_0000) begin
					next_state = TSR_H_WAIT;
					next_cnt = 32'(MRST_WAIT_CYC - 1);
					next_pin_out = 1'b0;
					next_pin_oe = 1'b0;
				end else begin
					next_cnt = cnt - 32'h0000_0001;
				end
			end
			TSR_H_WAIT: begin
				if (cnt == 32'h0000_0000) begin
					next_state = TSR_H_READY;
					next_ready = 1'b1;
				end else begin
					next_cnt = cnt - 32'h0000_0001;
				end
			end
			TSR_H_READY: begin
				next_ready = 1'b1;
				if (sw_reset_req) begin
					next_state = TSR_H_PULSE;
					next_cnt = 32'(MRST_PULSE_CYC - 1);
					next_pin_out = 1'b1;
					next_pin_oe = 1'b1;
					next_ready = 1'b0;
				end
			end
			default: next_state = TSR_H_POR;
		endcase
		// accesses pass only while ready; others are dropped
		next_wr = ready && sw_wr && !sw_reset_req;
		next_rd = ready && sw_rd && !sw_reset_req;
		next_addr = sw_addr;
		next_wdata = sw_wdata;
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= TSR_H_POR;
			cnt <= 32'(POR_WAIT_CYC - 1);
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			addr <= 7'h00;
			wdata <= 8'h00;
			wr <= 1'b0;
			rd <= 1'b0;
			rd_d <= 1'b0;
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			ready <= 1'b0;
			sw_rdata <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ck_s1 <= link.clock_output_pin;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			addr <= next_addr;
			wdata <= next_wdata;
			wr <= next_wr;
			rd <= next_rd;
			rd_d <= rd;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			ready <= next_ready;
			sw_rdata <= rd_d ? link.rdata : 8'h00;
		end
	end
	assign link.addr = addr;
	assign link.wdata = wdata;
	assign link.wr = wr;
	assign link.rd = rd;
	assign link.rst_pin_out = pin_out;
	assign link.rst_pin_oe = pin_oe;
endmodule // tsr_host

// [sim/tsr_link_properties.sv]
// tsr_link_properties.sv: link checker for the temperature/tuning pair
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/100ps
`include "tsr_map.svh"
module tsr_link_properties #(
	parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
	parameter int MRST_WAIT_CYC = 16
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic rst_pin_out,
	input wire logic rst_pin_oe,
	input wire logic clock_output_pin
);
	logic pin_high;
	logic [15:0] quiet_cnt;
	logic [15:0] next_quiet_cnt;
	assign pin_high = rst_pin_oe & rst_pin_out;
	// saturates so a long idle run never wraps into a false hit
	always_comb begin
		next_quiet_cnt = quiet_cnt;
		if (rst_pin_oe)
			next_quiet_cnt = 16'h0000;
		else if (quiet_cnt != 16'hffff)
			next_quiet_cnt = quiet_cnt + 16'h0001;
	end
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			quiet_cnt <= 16'hffff;
		else
			quiet_cnt <= next_quiet_cnt;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ****
	// assertions
	// ****
	AST_TRIG_READS_ZERO: assert property (
		rd && addr == `TSR_ADDR_TEMP_CTL |=> rdata[3] == 1'b0
		&& rdata[7:4] == 4'h0 && rdata[1:0] == 2'b01)
		else $error("control byte reads wrong");
	AST_BUSY_SEEN: assert property (
		wr && addr == `TSR_ADDR_TEMP_CTL && wdata[3]
		##[1:8] rd && addr == `TSR_ADDR_TEMP_CTL |=> rdata[2])
		else $error("busy flag low during conversion");
	AST_REVISION: assert property (
		rd && addr == `TSR_ADDR_REVISION |=> rdata == REVISION)
		else $error("revision code wrong");
	AST_CLOCK_OUTPUT_PIN_RUNS: assert property (
		!pin_high [*8] |=> clock_output_pin != $past(clock_output_pin))
		else $error("clock output stalled");
	AST_CLOCK_OUTPUT_PIN_QUIET: assert property (
		pin_high [*6] |-> !clock_output_pin)
		else $error("device not held by reset pin");
	AST_PULSE_LEN: assert property (
		$rose(rst_pin_oe) |-> pin_high [*8])
		else $error("reset pulse too short");
	AST_QUIET_AFTER_PULSE: assert property (
		wr || rd |-> quiet_cnt >= MRST_WAIT_CYC)
		else $error("access too soon after reset pulse");
	AST_FLOAT_AT_POR: assert property (
		$rose(resetn) |-> !rst_pin_oe [*8])
		else $error("reset pin driven during power-on");
	AST_NO_EARLY_ACCESS: assert property (
		$rose(resetn) |-> !(wr || rd) [*4])
		else $error("access right after power-on");
endmodule // tsr_link_properties

// [sim/temp_sense_tuning_reset_ctl_tb.sv]
// temp_sense_tuning_reset_ctl_tb.sv: self-checking bench, both ends
// assumes: design, package and link interface compiled first
`timescale 1ns/100ps
`include "tsr_map.svh"
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: %h not %h", $time, g, e); \
	end \
end
module temp_sense_tuning_reset_ctl_tb;
	import tsr_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam int CONV = 16;
	localparam tsr_byte_t FM [3] = '{8'h00, 8'h10, 8'h30};
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic sw_reset_req = 1'b0;
	tsr_addr_t sw_addr = 7'h00;
	tsr_byte_t sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	tsr_byte_t sw_rdata;
	logic ready;
	tsr_byte_t sensor_code = 8'h00;
	logic low_index_corr_enable = 1'b0;
	logic rx_allowed;
	logic lna_high_sens;
	tsr_byte_t fading_margin;
	logic signed [17:0] freq_offset_hz;
	int bad_count = 0;
	int num_checks = 0;
	int n;
	tsr_byte_t v;
	always #5 clk_sys = ~clk_sys;
	tsr_link_if i_tsr_link_if ();
	tsr_dev #(.REVISION(REV), .CONV_CYCLES(CONV)) i_tsr_dev (
		.clk_sys(clk_sys), .resetn(resetn), .link(i_tsr_link_if.dev),
		.sensor_code(sensor_code), .rx_allowed(rx_allowed),
		.lna_high_sens(lna_high_sens), .fading_margin(fading_margin),
		.low_index_corr_enable(low_index_corr_enable),
		.freq_offset_hz(freq_offset_hz));
	tsr_host #(.POR_WAIT_CYC(20), .MRST_PULSE_CYC(8), .MRST_WAIT_CYC(16))
	i_tsr_host (
		.clk_sys(clk_sys), .resetn(resetn), .link(i_tsr_link_if.host),
		.sw_reset_req(sw_reset_req), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .ready(ready));
	tsr_link_properties #(.REVISION(REV), .MRST_WAIT_CYC(16))
	i_tsr_link_properties (
		.clk_sys(clk_sys), .resetn(resetn), .addr(i_tsr_link_if.addr),
		.wdata(i_tsr_link_if.wdata), .wr(i_tsr_link_if.wr),
		.rd(i_tsr_link_if.rd), .rdata(i_tsr_link_if.rdata),
		.rst_pin_out(i_tsr_link_if.rst_pin_out),
		.rst_pin_oe(i_tsr_link_if.rst_pin_oe),
		.clock_output_pin(i_tsr_link_if.clock_output_pin));
	// ****
	// helpers
	// ****
	function automatic logic signed [17:0] f_off(tsr_byte_t s, logic en);
		return en ? $signed({{10{s[7]}}, s}) * 18'sh0_01e8 : 18'sh0_0000;
	endfunction
	task automatic test_done();
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_ready();
		n = 0;
		while (ready !== 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			$display("wrong value at %0t: ready timeout", $time);
			test_done();
		end
	endtask
	task automatic wr_reg(input tsr_addr_t a, input tsr_byte_t d);
		@(posedge clk_sys);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge clk_sys);
		sw_wr <= 1'b0;
	endtask
	// read data stands for one cycle, two edges after the strobe is taken
	task automatic rd_chk(input tsr_addr_t a, input tsr_byte_t e);
		@(posedge clk_sys);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge clk_sys);
		sw_rd <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(sw_rdata, e)
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(74788));
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		wait_ready();
		rd_chk(`TSR_ADDR_LNA, `TSR_LNA_RESET);
		`CHK(lna_high_sens, 1'b0)
		rd_chk(`TSR_ADDR_FADING, `TSR_FADING_RESET);
		rd_chk(`TSR_ADDR_LOWIDX, `TSR_LOWIDX_RESET);
		rd_chk(`TSR_ADDR_TEMP_CTL, `TSR_TEMP_CTL_FIXED);
		wr_reg(`TSR_ADDR_REVISION, 8'hff);
		rd_chk(`TSR_ADDR_REVISION, REV);
		rd_chk(7'h20, 8'h00);
		wr_reg(`TSR_ADDR_LNA, `TSR_LNA_HIGH);
		rd_chk(`TSR_ADDR_LNA, `TSR_LNA_HIGH);
		`CHK(lna_high_sens, 1'b1)
		for (int i = 0; i < 3; i++) begin
			wr_reg(`TSR_ADDR_FADING, FM[i]);
			rd_chk(`TSR_ADDR_FADING, FM[i]);
			`CHK(fading_margin, FM[i])
		end
		for (int i = 0; i < 6; i++) begin
			v = (i == 1) ? 8'h80 : 8'($urandom);
			@(posedge clk_sys);
			low_index_corr_enable <= i[0];
			wr_reg(`TSR_ADDR_LOWIDX, v);
			rd_chk(`TSR_ADDR_LOWIDX, v);
			`CHK(freq_offset_hz, f_off(v, i[0]))
		end
		// second trigger lands mid-run and must not stretch it
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			sensor_code <= 8'($urandom);
			wr_reg(`TSR_ADDR_TEMP_CTL, 8'h08);
			rd_chk(`TSR_ADDR_TEMP_CTL, 8'h05);
			`CHK(rx_allowed, 1'b0)
			wr_reg(`TSR_ADDR_TEMP_CTL, 8'hff);
			n = 0;
			// look after the edge so a flop's update is never raced
			while (rx_allowed !== 1'b1 && n < 100) begin
				@(posedge clk_sys);
				#1;
				n++;
			end
			`CHK((n > CONV - 10) && (n < CONV - 2), 1'b1)
			if (n >= 100)
				test_done();
			rd_chk(`TSR_ADDR_TEMP_CTL, `TSR_TEMP_CTL_FIXED);
			rd_chk(`TSR_ADDR_TEMP_VAL, ~sensor_code);
		end
		wr_reg(`TSR_ADDR_LNA, `TSR_LNA_HIGH);
		@(posedge clk_sys);
		sw_reset_req <= 1'b1;
		@(posedge clk_sys);
		sw_reset_req <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(ready, 1'b0)
		wait_ready();
		rd_chk(`TSR_ADDR_LNA, `TSR_LNA_RESET);
		`CHK(lna_high_sens, 1'b0)
		rd_chk(`TSR_ADDR_FADING, `TSR_FADING_RESET);
		`CHK(fading_margin, `TSR_FADING_RESET)
		test_done();
	end
endmodule // temp_sense_tuning_reset_ctl_tb
